// *** hw/mrsc_reset_ctrl.sv ***
// Operation
// [R01] Core halted for the whole reset state.
// [R02] Module registers loaded with defaults; power-on-only bits spared.
// [R03] Interrupts and timers disabled on reset entry.
// [R04] RAM contents untouched by any reset.
// [R05] Port latches set to one, pins open-drain during reset.
// [R06] Weak pullups enabled during and after reset.
// [R07] Supply monitor or power-on reset drives reset pin low.
// [R08] Program counter cleared to 0x0000 on reset exit.
// [R09] Low-power oscillator selected as system clock on exit.
// [R10] Watchdog enabled, clocked by low-frequency oscillator, on exit.
// [R11] Sources combined; held while any asserted; synchronous release.
`timescale 1ns/1ns
module mrsc_reset_ctrl
  import mrsc_pkg::*;
#(
  parameter int SRC_W = MRSC_SRC_W,
  parameter int PORT_W = MRSC_PORT_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [SRC_W-1:0] rstSrc,
  output logic inReset,
  output mrsc_core_ctl_t coreCtl,
  output logic [MRSC_PC_W-1:0] pcInit,
  output mrsc_clk_ctl_t clkCtl,
  output logic [PORT_W-1:0] portLatchSet,
  output logic portOpenDrain,
  output logic weakPullupEn,
  output logic rstPinOut,
  output logic rstPinOe,
  output logic ramWriteBlock
);

  mrsc_state_t state;
  mrsc_state_t next_state;
  logic anySrc;
  logic porSrc;
  logic pinLowSrc;
  logic next_inReset;
  logic next_coreHalt;
  logic next_regDefault;
  logic next_porDefault;
  logic next_intDisable;
  logic next_timerDisable;
  logic next_pcLoad;
  logic [MRSC_PC_W-1:0] next_pcInit;
  mrsc_clk_ctl_t next_clkCtl;
  logic [PORT_W-1:0] next_portLatchSet;
  logic next_portOpenDrain;
  logic next_weakPullupEn;
  logic next_rstPinOut;
  logic next_rstPinOe;
  logic next_ramWriteBlock;

  // Any request line, sys_rst included
  function automatic logic src_any(
    input logic rstIn,
    input logic [SRC_W-1:0] src
  );
    logic hit;
    hit = rstIn;
    for (int i = 0; i < SRC_W; i++) begin
      hit = hit | src[i];
    end
    return hit;
  endfunction

  // sys_rst counts as a power-on source
  function automatic logic src_por(
    input logic rstIn,
    input logic [SRC_W-1:0] src
  );
    logic hit;
    hit = rstIn | src[MRSC_SRC_POR];
    return hit;
  endfunction

  function automatic logic src_pin_low(
    input logic rstIn,
    input logic [SRC_W-1:0] src
  );
    logic hit;
    hit = src_por(rstIn, src) | src[MRSC_SRC_SUPPLY];
    return hit;
  endfunction

  // Unknown state codes count as reset, the safe side
  function automatic logic st_hold(input mrsc_state_t st);
    logic hold;
    case (st)
      MRSC_RUN: begin
        hold = 1'h0;
      end
      MRSC_HOLD: begin
        hold = 1'h1;
      end
      default: begin
        hold = 1'h1;
      end
    endcase
    return hold;
  endfunction

  assign anySrc = src_any(sys_rst, rstSrc); // [R11]
  assign porSrc = src_por(sys_rst, rstSrc); // [R02]
  assign pinLowSrc = src_pin_low(sys_rst, rstSrc); // [R07]

  always_comb begin
    next_state = state;
    case (state)
      MRSC_RUN: begin
        if (anySrc) begin
          next_state = MRSC_HOLD; // [R11]
        end else begin
          next_state = MRSC_RUN;
        end
      end
      MRSC_HOLD: begin
        if (anySrc) begin
          next_state = MRSC_HOLD;
        end else begin
          next_state = MRSC_RUN; // [R11]
        end
      end
      default: begin
        next_state = MRSC_HOLD;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= MRSC_HOLD;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    if (st_hold(next_state)) begin
      next_inReset = 1'h1; // [R11]
    end else begin
      next_inReset = 1'h0;
    end
  end

  always_comb begin
    if (st_hold(next_state)) begin
      next_coreHalt = 1'h1; // [R01]
    end else begin
      next_coreHalt = 1'h0;
    end
  end

  always_comb begin
    if (st_hold(next_state)) begin
      next_regDefault = 1'h1; // [R02]
    end else begin
      next_regDefault = 1'h0;
    end
  end

  // Power-on-only bits follow just the power-on sources
  always_comb begin
    if (porSrc) begin
      next_porDefault = 1'h1; // [R02]
    end else begin
      next_porDefault = 1'h0;
    end
  end

  always_comb begin
    if (st_hold(next_state)) begin
      next_intDisable = 1'h1; // [R03]
    end else begin
      next_intDisable = 1'h0;
    end
  end

  always_comb begin
    if (st_hold(next_state)) begin
      next_timerDisable = 1'h1; // [R03]
    end else begin
      next_timerDisable = 1'h0;
    end
  end

  always_comb begin
    if (st_hold(next_state)) begin
      next_pcLoad = 1'h1; // [R08]
    end else begin
      next_pcLoad = 1'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    inReset <= next_inReset; // [R11]
    coreCtl.coreHalt <= next_coreHalt; // [R01]
    coreCtl.regDefault <= next_regDefault; // [R02]
    coreCtl.porDefault <= next_porDefault; // [R02]
    coreCtl.intDisable <= next_intDisable; // [R03]
    coreCtl.timerDisable <= next_timerDisable; // [R03]
    coreCtl.pcLoad <= next_pcLoad; // [R08]
  end

  // Vector is fixed; the core takes it while pcLoad is high
  always_comb begin
    next_pcInit = MRSC_PC_RESET; // [R08]
  end

  always_ff @(posedge core_clk) begin
    pcInit <= next_pcInit;
  end

  // Loaded all through reset and held after, so values stand at exit
  always_comb begin
    next_clkCtl = clkCtl;
    case (next_state)
      MRSC_HOLD: begin
        next_clkCtl.sysClkSel = MRSC_SYSCLK_LOWPWR; // [R09]
        next_clkCtl.wdtEnable = 1'h1; // [R10]
        next_clkCtl.wdtClkSel = MRSC_WDT_LOW_FREQ_OSC; // [R10]
      end
      MRSC_RUN: begin
        next_clkCtl = clkCtl;
      end
      default: begin
        next_clkCtl = clkCtl;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    clkCtl <= next_clkCtl;
  end

  always_comb begin
    if (st_hold(next_state)) begin
      next_portLatchSet = '1; // [R05]
    end else begin
      next_portLatchSet = '0;
    end
  end

  always_comb begin
    if (st_hold(next_state)) begin
      next_portOpenDrain = 1'h1; // [R05]
    end else begin
      next_portOpenDrain = 1'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    portLatchSet <= next_portLatchSet;
    portOpenDrain <= next_portOpenDrain;
  end

  // Pullups stay on; later control belongs to port logic
  always_comb begin
    next_weakPullupEn = 1'h1; // [R06]
  end

  always_ff @(posedge core_clk) begin
    weakPullupEn <= next_weakPullupEn;
  end

  // Kept low until exit even when the power-on source drops first
  always_comb begin
    next_rstPinOe = 1'h0;
    case (next_state)
      MRSC_HOLD: begin
        if (pinLowSrc || rstPinOe) begin
          next_rstPinOe = 1'h1; // [R07]
        end
      end
      MRSC_RUN: begin
        next_rstPinOe = 1'h0;
      end
      default: begin
        next_rstPinOe = pinLowSrc; // [R07]
      end
    endcase
  end

  // Open-drain style: only ever drives low
  always_comb begin
    next_rstPinOut = 1'h0;
  end

  always_ff @(posedge core_clk) begin
    rstPinOut <= next_rstPinOut;
    rstPinOe <= next_rstPinOe;
  end

  // Never write-protect RAM from reset; only hold off core access
  always_comb begin
    next_ramWriteBlock = 1'h0; // [R04]
  end

  always_ff @(posedge core_clk) begin
    ramWriteBlock <= next_ramWriteBlock;
  end

endmodule

// *** hw/mrsc_pkg.sv ***
package mrsc_pkg;
  localparam int MRSC_PC_W = 16;
  localparam logic [15:0] MRSC_PC_RESET = 16'h0000;
  localparam int MRSC_PORT_W = 8;
  localparam int MRSC_SRC_W = 4;
  // Reset source bit positions
  localparam int MRSC_SRC_POR = 0;
  localparam int MRSC_SRC_SUPPLY = 1;
  localparam int MRSC_SRC_PIN = 2;
  localparam int MRSC_SRC_OTHER = 3;
  // Clock source selects
  localparam logic [1:0] MRSC_SYSCLK_LOWPWR = 2'h0;
  localparam logic [1:0] MRSC_WDT_LOW_FREQ_OSC = 2'h1;

  typedef enum logic [1:0] {
    MRSC_RUN = 2'h1,
    MRSC_HOLD = 2'h2
  } mrsc_state_t;

  typedef struct packed {
    logic coreHalt;
    logic regDefault;
    logic porDefault;
    logic intDisable;
    logic timerDisable;
    logic pcLoad;
  } mrsc_core_ctl_t;

  typedef struct packed {
    logic [1:0] sysClkSel;
    logic wdtEnable;
    logic [1:0] wdtClkSel;
  } mrsc_clk_ctl_t;
endpackage

// *** tb/mrsc_properties.sv ***
`timescale 1ns/1ns
module mrsc_properties import mrsc_pkg::*; (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [MRSC_SRC_W-1:0] rstSrc,
  input wire logic inReset,
  input wire mrsc_core_ctl_t coreCtl,
  input wire mrsc_clk_ctl_t clkCtl,
  input wire logic [MRSC_PORT_W-1:0] portLatchSet,
  input wire logic rstPinOe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence sExit; $fell(inReset); endsequence
  chk_core_halt: assert property (|rstSrc |=> coreCtl.coreHalt)
    else $error("halt");
  chk_reg_dflt: assert property (|rstSrc |=> coreCtl.regDefault)
    else $error("dflt");
  chk_irq_off: assert property (|rstSrc |=> coreCtl.intDisable)
    else $error("irq");
  chk_sync_rel: assert property (!(|rstSrc) |=> !inReset)
    else $error("rel");
  chk_pin_low: assert property (|rstSrc[1:0] |=> rstPinOe)
    else $error("pin");
  chk_pin_free: assert property (!(|rstSrc) |=> !rstPinOe)
    else $error("free");
  chk_pin_hold: assert property (rstPinOe && (|rstSrc) |=> rstPinOe)
    else $error("hold");
  chk_port_known: assert property (inReset |-> &portLatchSet)
    else $error("port");
  chk_exit_wdt: assert property (sExit |-> clkCtl.wdtEnable)
    else $error("wdt");
endmodule
bind mrsc_reset_ctrl mrsc_properties p_i(.*);

// *** tb/mrsc_src_model.sv ***
`timescale 1ns/1ns
module mrsc_src_model (
  input wire logic core_clk,
  input wire logic [3:0] want,
  output logic [3:0] rstSrc
);
  initial rstSrc = 4'h0;
  always @(posedge core_clk) rstSrc <= #1 want;
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ns
module tb;
  import mrsc_pkg::*;
  logic core_clk = 0, sys_rst = 1, inReset, portOpenDrain;
  logic weakPullupEn, rstPinOut, rstPinOe, ramWriteBlock;
  logic [3:0] want = 4'h0, rstSrc;
  logic [7:0] portLatchSet;
  logic [15:0] pcInit;
  mrsc_core_ctl_t coreCtl;
  mrsc_clk_ctl_t clkCtl;
  int err_total = 0, n_checks = 0, cyc = 0;
  always #20 core_clk = ~core_clk;
  mrsc_src_model mrsc_src_model_i(.*);
  mrsc_reset_ctrl mrsc_reset_ctrl_i(.*);
  task automatic chk(logic [15:0] g, e);
    n_checks++;
    if (g !== e) err_total++;
    if (g !== e) $display("CHECK FAILED %0t %h %h", $time, g, e);
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Ceiling well above the 42 cycles the run needs
  always @(posedge core_clk) if (++cyc > 99) begin err_total++; test_done; end
  task automatic t_src(int b);
    want = 4'h1 << b;
    repeat (3) @(posedge core_clk);
    #2 chk(inReset, 16'h1);
    chk(rstPinOe, 16'(b < 2));
    chk(coreCtl, {2'h3, 1'(b == 0), 3'h7});
    chk(portLatchSet, 16'hff);
    chk(portOpenDrain, 16'h1);
    chk(rstPinOut, 16'h0);
    chk(weakPullupEn, 16'h1);
    want = 4'h0;
    repeat (3) @(posedge core_clk);
    #2 chk(clkCtl, {MRSC_SYSCLK_LOWPWR, 1'h1, MRSC_WDT_LOW_FREQ_OSC});
    chk(inReset, 16'h0);
    chk(coreCtl, 16'h0);
    chk(portLatchSet, 16'h0);
    chk(portOpenDrain, 16'h0);
    chk(rstPinOe, 16'h0);
    chk(weakPullupEn, 16'h1);
    chk(pcInit, MRSC_PC_RESET);
    chk(ramWriteBlock, 16'h0);
  endtask
  task automatic t_overlap;
    want = 4'h2;
    repeat (3) @(posedge core_clk);
    #2 chk(rstPinOe, 16'h1);
    want = 4'h4;
    repeat (3) @(posedge core_clk);
    #2 chk(rstPinOe, 16'h1);
    chk(inReset, 16'h1);
    want = 4'h0;
    repeat (3) @(posedge core_clk);
    #2 chk(rstPinOe, 16'h0);
    chk(inReset, 16'h0);
  endtask
  task automatic t_midrst;
    sys_rst = 1;
    repeat (2) @(posedge core_clk);
    #2 chk(rstPinOe, 16'h1);
    chk(coreCtl, 16'h3f);
    sys_rst = 0;
    repeat (2) @(posedge core_clk);
    #2 chk(inReset, 16'h0);
    chk(clkCtl, {MRSC_SYSCLK_LOWPWR, 1'h1, MRSC_WDT_LOW_FREQ_OSC});
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    #2 sys_rst = 0;
    for (int b = 0; b < 4; b++) t_src(b);
    t_overlap;
    t_midrst;
    test_done;
  end
endmodule
